// ===== verilog/flash_cmd_host.sv
// Flash command host: issues autoselect entry, exit, array/id reads and word/byte program,
// then polls the toggle status bit until the program completes.
// Assumes a single-request user port held until req_ready_out and done pulses.
`timescale 1ns/1ps
module flash_cmd_host
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic req_valid_in,
    input flash_host_pkg::req_t req_in,
    input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
    output logic req_ready_out,
    output logic done_out,
    output logic [flash_host_pkg::DATA_W-1:0] rdata_out,
    output logic in_autosel_out,
    output logic busy_out,
    output flash_host_pkg::pins_t pins_out
);
    import flash_host_pkg::*;

    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_ISSUE = 5'b00010,
        H_WAIT = 5'b00100,
        H_POLL = 5'b01000,
        H_DONE = 5'b10000
    } hstate_t;

    hstate_t state_q, state_d;
    req_t req_q, req_d;
    logic [2:0] step_q, step_d;
    logic auto_q, auto_d;
    logic [DATA_W-1:0] prev_q, prev_d;
    logic first_q, first_d;
    logic ready_q, ready_d;
    logic done_q, done_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic start;
    cycle_t cyc;
    logic cyc_done;
    logic [DATA_W-1:0] cyc_rdata;

    // Cycle number n of the chosen sequence; the last step is marked by seq_last.
    function automatic cycle_t seq_cycle(input req_t r, input logic [2:0] n);
        cycle_t c;
        logic [ADDR_W-1:0] a1;
        logic [ADDR_W-1:0] a2;
        a1 = r.byte_mode ? BYTE_UNLOCK1 : WORD_UNLOCK1;
        a2 = r.byte_mode ? BYTE_UNLOCK2 : WORD_UNLOCK2;
        c = '{is_read: 1'b0, addr: a1, data: CMD_UNLOCK1};
        case (n)
            3'h1: c = '{is_read: 1'b0, addr: a2, data: CMD_UNLOCK2};
            3'h2: c = '{is_read: 1'b0, addr: a1,
                        data: (r.op == OP_PROGRAM) ? CMD_PROGRAM : CMD_AUTOSEL};
            3'h3: c = '{is_read: 1'b0, addr: r.addr,
                        data: r.byte_mode ? {8'h00, r.data[7:0] & BYTE_MASK} : r.data};
            default: c = c;
        endcase
        if (r.op == OP_EXIT)
        begin
            c = '{is_read: 1'b0, addr: r.addr, data: CMD_EXIT};
        end
        if (r.op == OP_READ)
        begin
            c = '{is_read: 1'b1, addr: r.addr, data: '0};
        end
        return c;
    endfunction

    // Number of bus cycles minus one for each operation.
    function automatic logic [2:0] seq_last(input op_t op);
        case (op)
            OP_AUTOSEL: seq_last = 3'h2;
            OP_PROGRAM: seq_last = 3'h3;
            default: seq_last = 3'h0;
        endcase
    endfunction

    // Sequencer. A program leaves the host waiting on the toggle bit, so no other command
    // is ever sent while the device is busy; the device would ignore it anyway.
    always_comb
    begin
        state_d = state_q;
        req_d = req_q;
        step_d = step_q;
        auto_d = auto_q;
        prev_d = prev_q;
        first_d = first_q;
        ready_d = 1'b0;
        done_d = 1'b0;
        rdata_d = rdata_q;
        start = 1'b0;
        cyc = seq_cycle(req_q, step_q);
        case (state_q)
            H_IDLE:
            begin
                ready_d = 1'b1;
                if (req_valid_in && ready_q)
                begin
                    req_d = req_in;
                    step_d = 3'h0;
                    ready_d = 1'b0;
                    state_d = H_ISSUE;
                end
            end
            H_ISSUE:
            begin
                start = 1'b1;
                state_d = H_WAIT;
            end
            H_WAIT:
            begin
                if (cyc_done)
                begin
                    if (step_q != seq_last(req_q.op))
                    begin
                        step_d = step_q + 3'h1;
                        state_d = H_ISSUE;
                    end
                    else if (req_q.op == OP_PROGRAM)
                    begin
                        auto_d = 1'b0;
                        first_d = 1'b1;
                        req_d.op = OP_READ;
                        state_d = H_POLL;
                    end
                    else
                    begin
                        if (req_q.op == OP_AUTOSEL)
                        begin
                            auto_d = 1'b1;
                        end
                        if (req_q.op == OP_EXIT)
                        begin
                            auto_d = 1'b0;
                        end
                        rdata_d = cyc_rdata;
                        state_d = H_DONE;
                    end
                end
            end
            H_POLL:
            begin
                // Each status read reissues a read cycle at the target address.
                if (first_q)
                begin
                    start = 1'b1;
                    state_d = H_WAIT;
                    prev_d = '0;
                end
                else
                begin
                    state_d = H_DONE;
                end
            end
            H_DONE:
            begin
                done_d = 1'b1;
                state_d = H_IDLE;
            end
            default:
            begin
                state_d = H_IDLE;
            end
        endcase
        // Toggle polling: two reads in a row with the same toggle bit mean the program has finished.
        if (state_q == H_WAIT && cyc_done && req_q.op == OP_READ && busy_out)
        begin
            if (!first_q && prev_q[TOGGLE_BIT] == cyc_rdata[TOGGLE_BIT])
            begin
                rdata_d = cyc_rdata;
                state_d = H_DONE;
            end
            else
            begin
                // The first status read only seeds the history, so it can never end the poll.
                prev_d = cyc_rdata;
                first_d = 1'b0;
                state_d = H_ISSUE;
            end
        end
    end

    logic busy_q, busy_d;

    // Busy covers the whole status poll of a program.
    always_comb
    begin
        busy_d = busy_q;
        if (state_q == H_WAIT && cyc_done && req_q.op == OP_PROGRAM && step_q == 3'h3)
        begin
            busy_d = 1'b1;
        end
        if (state_q == H_DONE)
        begin
            busy_d = 1'b0;
        end
    end

    // Registers only; a reset here drops any poll so the program must be resent.
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            state_q <= H_IDLE;
            req_q <= '0;
            step_q <= 3'h0;
            auto_q <= 1'b0;
            prev_q <= '0;
            first_q <= 1'b0;
            ready_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= '0;
            busy_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            req_q <= req_d;
            step_q <= step_d;
            auto_q <= auto_d;
            prev_q <= prev_d;
            first_q <= first_d;
            ready_q <= ready_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
            busy_q <= busy_d;
        end
    end

    flash_bus_cycle flash_bus_cycle_i
    (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(start),
        .cyc_in(cyc),
        .dq_in(dq_in),
        .pins_out(pins_out),
        .done_out(cyc_done),
        .rdata_out(cyc_rdata)
    );

    assign req_ready_out = ready_q;
    assign done_out = done_q;
    assign rdata_out = rdata_q;
    assign in_autosel_out = auto_q;
    assign busy_out = busy_q;
endmodule

// ===== pkg/flash_host_pkg.sv
// Constants, types and command codes for the parallel flash command host.
// Assumes a NOR flash on an asynchronous chip-select/write/output-enable bus.
// Operation
// - Autoselect entry is the three writes AAh at 555h, 55h at 2AAh and 90h at 555h.
// - One write of F0h anywhere in the device leaves autoselect for array reads.
// - Every write cycle holds chip select and write strobe low and output enable high.
// - A program is AAh at 555h, 55h at 2AAh, A0h at 555h, then data at the target.
// - A hardware reset aborts a program, which must be reissued from read mode.
// - Program progress is read from data-bus status bits until completion.
package flash_host_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] WORD_UNLOCK1 = 24'h000555;
    localparam logic [ADDR_W-1:0] WORD_UNLOCK2 = 24'h0002aa;
    localparam logic [ADDR_W-1:0] BYTE_UNLOCK1 = 24'h000aaa;
    localparam logic [ADDR_W-1:0] BYTE_UNLOCK2 = 24'h000555;
    localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 16'h00aa;
    localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 16'h0055;
    localparam logic [DATA_W-1:0] CMD_AUTOSEL = 16'h0090;
    localparam logic [DATA_W-1:0] CMD_EXIT = 16'h00f0;
    localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00a0;
    localparam logic [7:0] BYTE_MASK = 8'hff;
    localparam int TOGGLE_BIT = 6;
    // Bus phase timing in 100 ns clock cycles.
    localparam int CLK_NS = 100;
    localparam int SETUP_NS = 100;
    localparam int PULSE_NS = 100;
    localparam int HOLD_NS = 100;
    localparam int READ_NS = 200;
    localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] PULSE_CYC = 4'((PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] READ_CYC = 4'((READ_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_AUTOSEL = 2'h1,
        OP_EXIT = 2'h2,
        OP_PROGRAM = 2'h3
    } op_t;

    typedef struct packed {
        op_t op;
        logic byte_mode;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } req_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
        logic dq_oe;
    } pins_t;

    typedef struct packed {
        logic is_read;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cycle_t;
endpackage

// ===== verilog/flash_bus_cycle.sv
// Single asynchronous flash bus cycle engine: one write or one read.
// Assumes pins are sampled synchronously to ref_clk_in.
`timescale 1ns/1ps
module flash_bus_cycle
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    input flash_host_pkg::cycle_t cyc_in,
    input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
    output flash_host_pkg::pins_t pins_out,
    output logic done_out,
    output logic [flash_host_pkg::DATA_W-1:0] rdata_out
);
    import flash_host_pkg::*;

    typedef enum logic [3:0] {
        C_IDLE = 4'b0001,
        C_SETUP = 4'b0010,
        C_PULSE = 4'b0100,
        C_HOLD = 4'b1000
    } cstate_t;

    cstate_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    cycle_t cyc_q, cyc_d;
    pins_t pins_q, pins_d;
    logic done_q, done_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;

    // Chip select falls with address and data set up; the strobe pulses inside it, so
    // the strobe falls last and rises first and the device latches on the strobe edges.
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        cyc_d = cyc_q;
        pins_d = pins_q;
        done_d = 1'b0;
        rdata_d = rdata_q;
        case (state_q)
            C_IDLE:
            begin
                if (start_in)
                begin
                    cyc_d = cyc_in;
                    pins_d.addr = cyc_in.addr;
                    pins_d.dq = cyc_in.data;
                    pins_d.dq_oe = ~cyc_in.is_read;
                    pins_d.ce_n = 1'b0;
                    pins_d.oe_n = 1'b1;
                    cnt_d = SETUP_CYC;
                    state_d = C_SETUP;
                end
            end
            C_SETUP:
            begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1)
                begin
                    if (cyc_q.is_read)
                    begin
                        pins_d.oe_n = 1'b0;
                        cnt_d = READ_CYC;
                    end
                    else
                    begin
                        pins_d.we_n = 1'b0;
                        cnt_d = PULSE_CYC;
                    end
                    state_d = C_PULSE;
                end
            end
            C_PULSE:
            begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1)
                begin
                    if (cyc_q.is_read)
                    begin
                        rdata_d = dq_in;
                    end
                    pins_d.we_n = 1'b1;
                    pins_d.oe_n = 1'b1;
                    cnt_d = HOLD_CYC;
                    state_d = C_HOLD;
                end
            end
            C_HOLD:
            begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1)
                begin
                    pins_d.ce_n = 1'b1;
                    pins_d.dq_oe = 1'b0;
                    done_d = 1'b1;
                    state_d = C_IDLE;
                end
            end
            default:
            begin
                state_d = C_IDLE;
            end
        endcase
    end

    // Registers only; synchronous reset parks the bus idle with all strobes high.
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            state_q <= C_IDLE;
            cnt_q <= 4'h0;
            cyc_q <= '0;
            pins_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq: '0, dq_oe: 1'b0};
            done_q <= 1'b0;
            rdata_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            cyc_q <= cyc_d;
            pins_q <= pins_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
        end
    end

    assign pins_out = pins_q;
    assign done_out = done_q;
    assign rdata_out = rdata_q;
endmodule

// ===== dv/flash_cmd_host_checker.sv
// Port timing checks for the flash command host.
// Assumes it is bound into flash_cmd_host and sees only its ports.
`timescale 1ns/1ps
module flash_cmd_host_checker
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic req_ready_out,
    input wire logic done_out,
    input wire logic in_autosel_out,
    input wire logic busy_out,
    input flash_host_pkg::pins_t pins_out
);
    import flash_host_pkg::*;
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // A write ends where the strobe rises while the chip is still selected.
    sequence wr_end;
        $rose(pins_out.we_n) && !pins_out.ce_n;
    endsequence

    // Bus levels, latch stability, command offsets and status flags.
    chk_write_levels: assert property (!pins_out.we_n |->
        !pins_out.ce_n && pins_out.oe_n && pins_out.dq_oe) else $error("bad write levels");
    chk_read_quiet: assert property (!pins_out.oe_n |->
        pins_out.we_n && !pins_out.dq_oe) else $error("read while driving");
    chk_latch_hold: assert property ($fell(pins_out.we_n) |->
        $stable({pins_out.addr, pins_out.dq})[*2]) else $error("moved under strobe");
    chk_unlock_addr: assert property (wr_end ##0 pins_out.dq == CMD_UNLOCK1 |->
        pins_out.addr == WORD_UNLOCK1 || pins_out.addr == BYTE_UNLOCK1)
        else $error("unlock at wrong offset");
    chk_setup_addr: assert property (wr_end ##0 pins_out.dq == CMD_PROGRAM |->
        pins_out.addr == WORD_UNLOCK1 || pins_out.addr == BYTE_UNLOCK1)
        else $error("setup at wrong offset");
    chk_autosel_flag: assert property (wr_end ##0 pins_out.dq == CMD_AUTOSEL |->
        ##[0:6] in_autosel_out) else $error("entry flag missing");
    chk_exit_flag: assert property (wr_end ##0 pins_out.dq == CMD_EXIT |->
        ##[0:6] !in_autosel_out) else $error("exit flag stuck");
    chk_busy_quiet: assert property (busy_out && $past(busy_out, 2) |->
        pins_out.we_n) else $error("write while busy");
    chk_busy_done: assert property ($fell(busy_out) |-> ##[0:2] done_out)
        else $error("no done after polling");
    chk_done_ready: assert property (done_out |=> !done_out ##[0:1] req_ready_out)
        else $error("done not a pulse or no ready");
    cover property ($fell(busy_out));
    cover property ($rose(in_autosel_out));
    cover property ($fell(in_autosel_out));
endmodule

bind flash_cmd_host flash_cmd_host_checker flash_cmd_host_checker_i (.*);

// ===== dv/flash_dev_model.sv
// Behavioural flash device answering the command host's pins.
// Assumes the pins are sampled on the host clock; no erase, suspend or bypass.
`timescale 1ns/1ps
module flash_dev_model
#(
    parameter logic [15:0] ID_CODE = 16'h5a3c, // Arbitrary value.
    parameter int BUSY_READS = 3
)
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic byte_mode_in,
    input flash_host_pkg::pins_t pins_in,
    output logic [15:0] dq_out
);
    import flash_host_pkg::*;
    logic [15:0] mem [logic [23:0]];
    logic [15:0] rd_q = 16'h0000;
    logic we_q = 1'b1;
    logic oe_q = 1'b1;
    logic tog_q = 1'b0;
    int st = 0;
    int busy = 0;

    // Command decoder; any stray write drops a partial sequence.
    task automatic cmd_write(input logic [23:0] a, input logic [15:0] d);
        logic [23:0] u1;
        logic [23:0] u2;
        logic [15:0] c;
        logic [15:0] m;
        u1 = byte_mode_in ? BYTE_UNLOCK1 : WORD_UNLOCK1;
        u2 = byte_mode_in ? BYTE_UNLOCK2 : WORD_UNLOCK2;
        c = byte_mode_in ? {8'h00, d[7:0]} : d;
        m = byte_mode_in ? {8'hff, d[7:0]} : d;
        if (busy > 0)
            return;
        if (st == 4)
        begin
            mem[a] = (mem.exists(a) ? mem[a] : 16'hffff) & m;
            busy = BUSY_READS;
            st = 0;
        end
        else if (c == CMD_EXIT)
            st = 0;
        else if (st == 3)
            st = 3;
        // Bypass is not offered here, so a program sent without its unlocks is lost.
        else if (st == 0 && a == u1 && c == CMD_UNLOCK1)
            st = 1;
        else if (st == 1 && a == u2 && c == CMD_UNLOCK2)
            st = 2;
        else if (st == 2 && a == u1 && (c == CMD_AUTOSEL || c == CMD_PROGRAM))
            st = (c == CMD_AUTOSEL) ? 3 : 4;
        else
            st = 0;
    endtask

    // Status toggles while busy; array data returns once the count runs out.
    task automatic cmd_read(input logic [23:0] a);
        if (busy > 0)
        begin
            tog_q = ~tog_q;
            rd_q = {9'h000, tog_q, 6'h00};
            busy = busy - 1;
        end
        else if (st == 3)
            rd_q = ID_CODE;
        else
            rd_q = mem.exists(a) ? mem[a] : 16'hffff;
        if (byte_mode_in)
            rd_q[15:8] = 8'h00;
    endtask

    // Writes are taken on the rising strobe, reads on the falling enable.
    always @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            busy = 0;
            st = 0;
        end
        if (pins_in.we_n && !we_q && !pins_in.ce_n)
            cmd_write(pins_in.addr, pins_in.dq);
        if (!pins_in.oe_n && oe_q && !pins_in.ce_n)
            cmd_read(pins_in.addr);
        we_q <= pins_in.we_n;
        oe_q <= pins_in.oe_n;
    end

    // A released bus shows the inverse so stale data cannot pass for an answer.
    assign dq_out = (!pins_in.ce_n && !pins_in.oe_n) ? rd_q : ~rd_q;
endmodule

// ===== dv/flash_cmd_host_tb.sv
// Self-checking bench: command host against a behavioural flash device.
// Assumes one request at a time, each ended by a done pulse except the program that test_reset cuts short with a reset.
`timescale 1ns/1ps
module flash_cmd_host_tb;
    import flash_host_pkg::*;
    localparam logic [15:0] ID = 16'h5a3c; // Arbitrary value.
    logic clk;
    logic rst;
    logic valid;
    logic bm;
    logic seen_busy;
    req_t req;
    pins_t pins;
    logic [15:0] dev_dq;
    logic [15:0] dq_bus;
    logic [15:0] rdata;
    logic ready;
    logic done;
    logic in_auto;
    logic busy;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;

    flash_cmd_host flash_cmd_host_i (.ref_clk_in(clk), .sys_rst_in(rst), .req_valid_in(valid),
        .req_in(req), .dq_in(dq_bus), .req_ready_out(ready), .done_out(done),
        .rdata_out(rdata), .in_autosel_out(in_auto), .busy_out(busy), .pins_out(pins));
    flash_dev_model #(.ID_CODE(ID)) flash_dev_model_i (.ref_clk_in(clk), .rst_in(rst),
        .byte_mode_in(bm), .pins_in(pins), .dq_out(dev_dq));

    // The host owns the data lines whenever its drivers are on.
    assign dq_bus = pins.dq_oe ? pins.dq : dev_dq;

    // Free-running reference clock.
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // A hang is cut short well past the few hundred cycles the tests need.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One request, held until taken, then a bounded wait for done.
    task automatic run(input op_t op, input logic [23:0] a, input logic [15:0] d);
        int n;
        n = 0;
        req = '{op: op, byte_mode: bm, addr: a, data: d};
        valid = 1'b1;
        while (ready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge clk) #1;
        end
        @(posedge clk) #1;
        valid = 1'b0;
        seen_busy = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 3000)
        begin
            seen_busy |= (busy === 1'b1);
            n++;
            @(posedge clk) #1;
        end
        check({15'h0000, done}, 16'h0001);
    endtask

    task automatic read_expect(input logic [23:0] a, input logic [15:0] exp);
        run(OP_READ, a, 16'h0000);
        check(rdata, exp);
    endtask

    // Identification data persists over reads until an exit at any offset.
    task automatic test_autosel();
        run(OP_AUTOSEL, 24'h000000, 16'h0000);
        check({15'h0000, in_auto}, 16'h0001);
        read_expect(24'h000000, ID);
        read_expect(24'h000101, ID);
        run(OP_EXIT, 24'h3c0123, 16'h0000);
        check({15'h0000, in_auto}, 16'h0000);
        read_expect(24'h000101, 16'hffff);
    endtask

    // Word programs in falling address order, one word cleared twice.
    task automatic test_program();
        run(OP_PROGRAM, 24'h7f0010, 16'h1234);
        check({15'h0000, seen_busy}, 16'h0001);
        check(rdata, 16'h1234);
        read_expect(24'h7f0010, 16'h1234);
        run(OP_PROGRAM, 24'h7f0010, 16'h0ff0);
        read_expect(24'h7f0010, 16'h0230);
        run(OP_PROGRAM, 24'h000020, 16'habcd);
        read_expect(24'h000020, 16'habcd);
        read_expect(24'h7f0010, 16'h0230);
    endtask

    // A byte program needs the byte offsets and keeps only the low byte.
    task automatic test_byte();
        bm = 1'b1;
        run(OP_PROGRAM, 24'h000041, 16'hc35a);
        read_expect(24'h000041, 16'h005a);
        bm = 1'b0;
    endtask

    // A reset in mid-poll parks the bus; the resent program then lands normally.
    task automatic test_reset();
        int n;
        n = 0;
        req = '{op: OP_PROGRAM, byte_mode: bm, addr: 24'h000300, data: 16'h00ff};
        valid = 1'b1;
        while (ready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge clk) #1;
        end
        @(posedge clk) #1;
        valid = 1'b0;
        n = 0;
        while (busy !== 1'b1 && n < 200)
        begin
            n++;
            @(posedge clk) #1;
        end
        check({15'h0000, busy}, 16'h0001);
        repeat (3) @(posedge clk) #1;
        rst = 1'b1;
        repeat (2) @(posedge clk) #1;
        check({11'h000, busy, pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe}, 16'h000e);
        rst = 1'b0;
        run(OP_PROGRAM, 24'h000300, 16'h00ff);
        check({15'h0000, seen_busy}, 16'h0001);
        read_expect(24'h000300, 16'h00ff);
    endtask

    // Reset with idle pins checked, then the scenarios and the verdict.
    initial
    begin
        rst = 1'b1;
        valid = 1'b0;
        bm = 1'b0;
        req = '0;
        repeat (20) @(posedge clk);
        #1;
        check({12'h000, pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe}, 16'h000e);
        rst = 1'b0;
        test_autosel();
        test_program();
        test_byte();
        test_reset();
        give_verdict();
    end
endmodule
